/* hdl/rsf_consts.svh */
// Constants of the return stack fault and shadow block: offsets, fields, resets, vectors.
`ifndef RSF_CONSTS_SVH
`define RSF_CONSTS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define RSF_PC_W 21
`define RSF_SP_W 5
`define RSF_ADR_W 8
`define RSF_EVT_W 3

// ----------------------------------------------------------------------------
// Interrupt vectors
// ----------------------------------------------------------------------------
`define RSF_VEC_HIGH 21'h000008
`define RSF_VEC_LOW 21'h000018

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define RSF_OFS_CTRL 8'h00
`define RSF_OFS_STACK 8'h04
`define RSF_OFS_TOS 8'h08
`define RSF_OFS_IRQ_STAT 8'h0C
`define RSF_OFS_IRQ_CLR 8'h10
`define RSF_OFS_IRQ_EN 8'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RSF_CTRL_FRE_BIT 0
`define RSF_STACK_FULL_BIT 7
`define RSF_STACK_UNF_BIT 6
`define RSF_EVT_FULL_BIT 0
`define RSF_EVT_UNF_BIT 1
`define RSF_EVT_RST_BIT 2

// ----------------------------------------------------------------------------
// Reset values and unmapped read value
// ----------------------------------------------------------------------------
`define RSF_CTRL_FRE_RST 1'b1
`define RSF_IRQ_EN_RST 3'h0
`define RSF_UNMAPPED_RD 32'h00000000

`endif

/* hdl/rsf_pkg.sv */
// Types shared by the return stack fault and shadow block.
`include "rsf_consts.svh"

package rsf_pkg;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] working_register;
		logic [7:0] bank_select_register;
	} rsf_ctx_type;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [`RSF_ADR_W-1:0] adr;
		logic [31:0] dat;
	} rsf_wb_req_type;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} rsf_wb_rsp_type;

	typedef struct packed {
		rsf_ctx_type shadow;
		rsf_ctx_type out;
		logic restore;
	} rsf_shadow_state_type;

	typedef struct packed {
		logic [`RSF_SP_W-1:0] sp;
		logic stack_full_flag;
		logic stack_underflow_flag;
		logic stack_fault_reset_enable;
		logic fault_pend;
		logic reset_out;
		logic [`RSF_EVT_W-1:0] irq_stat;
		logic [`RSF_EVT_W-1:0] irq_en;
		logic ack;
		logic [31:0] rdata;
		logic pc_load;
		logic [`RSF_PC_W-1:0] pc_value;
	} rsf_core_state_type;

endpackage : rsf_pkg

/* hdl/rsf_shadow.sv */
// One-level shadow copy of status, working and bank-select registers.
`timescale 1ns/100ps
`include "rsf_consts.svh"

module rsf_shadow (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic save_i,
	input wire logic restore_i,
	input wire rsf_pkg::rsf_ctx_type ctx_i,
	output rsf_pkg::rsf_ctx_type ctx_o,
	output logic restore_o
);

	rsf_pkg::rsf_shadow_state_type state_q;
	rsf_pkg::rsf_shadow_state_type state_d;

	// The copy has no bus path at all, so software can neither read nor write it.
	always_comb begin // see RULE4
		state_d = state_q;
		state_d.restore = 1'b0;
		if (save_i) begin
			state_d.shadow = ctx_i; // see RULE5 see RULE7 see RULE8
		end else if (restore_i) begin
			state_d.out = state_q.shadow; // see RULE6 see RULE8
			state_d.restore = 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign ctx_o = state_q.out;
	assign restore_o = state_q.restore;

	// A later save always replaces an earlier one, even mid-service.
	a_save_loads_copy: assert property (@(posedge clock_i) disable iff (!rstn_i) // see RULE7
		save_i |=> state_q.shadow == $past(ctx_i))
		else $error("shadow copy not loaded on save");

	a_restore_gives_copy: assert property (@(posedge clock_i) disable iff (!rstn_i) // see RULE6
		restore_i && !save_i |=> restore_o && ctx_o == $past(state_q.shadow))
		else $error("restore did not present shadow copy");

endmodule : rsf_shadow

/* hdl/rsf_core.sv */
// Return stack with fault detection, fault reset, shadow save and program counter loads.
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "rsf_consts.svh"

// Notes on behaviour
// RULE1 - Enabled fault sets flag, then resets device.
// RULE2 - Disabled fault sets flag, no device reset.
// RULE3 - Flags clear only by software or power-on.
// RULE4 - One hidden shadow per status, working, bank.
// RULE5 - Every interrupt vector saves the three registers.
// RULE6 - Fast interrupt return restores the three registers.
// RULE7 - High interrupt overwrites low interrupt's saved copy.
// RULE8 - Fast call saves, fast return restores.
// RULE9 - Interrupt wake-up loads high or low vector.
// RULE10 - Interrupt wake-up pushes program counter onto stack.
// RULE11 - Software keeps computed jump offsets even.
// RULE12 - Adding to counter low advances by offset.
// RULE13 - Fault reset keeps full and underflow flags.
module rsf_core #(
	parameter int unsigned DEPTH = 31
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire rsf_pkg::rsf_wb_req_type wb_i,
	output rsf_pkg::rsf_wb_rsp_type wb_o,
	input wire logic call_i,
	input wire logic return_i,
	input wire logic interrupt_return_op_i,
	input wire logic fast_i,
	input wire logic irq_vector_i,
	input wire logic irq_high_i,
	input wire logic wake_irq_i,
	input wire logic low_priority_global_enable_i,
	input wire logic high_priority_global_enable_i,
	input wire logic add_working_to_file_op_i,
	input wire logic [`RSF_PC_W-1:0] pc_i,
	input wire rsf_pkg::rsf_ctx_type ctx_i,
	output logic pc_load_o,
	output logic [`RSF_PC_W-1:0] pc_value_o,
	output logic ctx_restore_o,
	output rsf_pkg::rsf_ctx_type ctx_o,
	output logic [`RSF_SP_W-1:0] stack_pointer_o,
	output logic [`RSF_PC_W-1:0] top_of_stack_o,
	output logic stack_full_flag_o,
	output logic stack_underflow_flag_o,
	output logic device_reset_o,
	output logic irq_o
);

	// ------------------------------------------------------------------------
	// State and stack storage
	// ------------------------------------------------------------------------
	localparam logic [`RSF_SP_W-1:0] SP_TOP = `RSF_SP_W'(DEPTH);

	rsf_pkg::rsf_core_state_type state_q;
	rsf_pkg::rsf_core_state_type state_d;
	logic [`RSF_PC_W-1:0] stack_mem [DEPTH];

	logic wb_hit;
	logic wb_wr;
	logic vec_take;
	logic do_push;
	logic do_pop;
	logic save;
	logic restore;
	logic full_evt;
	logic unf_evt;
	logic mem_we;
	logic [`RSF_SP_W-1:0] mem_idx;
	logic [`RSF_PC_W-1:0] tos;
	logic [`RSF_EVT_W-1:0] evt;

	assign wb_hit = wb_i.cyc && wb_i.stb && !state_q.ack;
	assign wb_wr = wb_hit && wb_i.we && wb_i.sel[0];
	// An interrupt wake-up vectors only while one of the global enables is set.
	assign vec_take = irq_vector_i || (wake_irq_i && (low_priority_global_enable_i
		|| high_priority_global_enable_i)); // see RULE9
	assign tos = (state_q.sp == '0) ? '0 : stack_mem[state_q.sp - `RSF_SP_W'(1)];

	// ------------------------------------------------------------------------
	// Sequencer operations
	// ------------------------------------------------------------------------
	// Only one operation is honoured per cycle; vectoring wins over call,
	// call over return, and return over the computed jump.
	always_comb begin
		do_push = 1'b0;
		do_pop = 1'b0;
		save = 1'b0;
		restore = 1'b0;
		if (state_q.reset_out) begin
			do_push = 1'b0;
		end else if (vec_take) begin
			do_push = 1'b1; // see RULE10
			save = 1'b1; // see RULE5 see RULE7
		end else if (call_i) begin
			do_push = 1'b1;
			save = fast_i; // see RULE8
		end else if (return_i || interrupt_return_op_i) begin
			do_pop = 1'b1;
			restore = fast_i; // see RULE6 see RULE8
		end
	end

	assign full_evt = do_push && (state_q.sp == SP_TOP);
	assign unf_evt = do_pop && (state_q.sp == '0);
	assign mem_we = do_push && !full_evt;
	assign mem_idx = state_q.sp;
	assign evt = {state_q.reset_out, unf_evt, full_evt};

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		state_d.ack = wb_hit;
		state_d.pc_load = 1'b0;
		state_d.fault_pend = 1'b0;

		// Stack pointer: a stack fault reset returns it to zero, as any
		// device reset does, but leaves the flags for software to inspect.
		if (state_q.reset_out) begin
			state_d.sp = '0; // see RULE13
		end else if (mem_we) begin
			state_d.sp = state_q.sp + `RSF_SP_W'(1); // see RULE10
		end else if (do_pop && !unf_evt) begin
			state_d.sp = state_q.sp - `RSF_SP_W'(1);
		end

		// Program counter loads.
		if (!state_q.reset_out && vec_take) begin
			state_d.pc_load = 1'b1;
			state_d.pc_value = irq_high_i ? `RSF_VEC_HIGH : `RSF_VEC_LOW; // see RULE9
		end else if (do_pop) begin
			state_d.pc_load = 1'b1;
			state_d.pc_value = tos;
		end else if (!state_q.reset_out && !call_i && add_working_to_file_op_i) begin
			// An odd offset is not corrected; the sequencer fetches from the
			// byte address exactly as computed.
			state_d.pc_load = 1'b1;
			state_d.pc_value = pc_i + `RSF_PC_W'(ctx_i.working_register); // see RULE12 see RULE11
		end

		// Fault flags: a software write of zero clears, a new fault wins.
		if (wb_wr && wb_i.adr == `RSF_OFS_STACK) begin
			state_d.stack_full_flag = state_q.stack_full_flag
				&& wb_i.dat[`RSF_STACK_FULL_BIT]; // see RULE3
			state_d.stack_underflow_flag = state_q.stack_underflow_flag
				&& wb_i.dat[`RSF_STACK_UNF_BIT]; // see RULE3
		end
		if (full_evt) begin
			state_d.stack_full_flag = 1'b1; // see RULE1 see RULE2
		end
		if (unf_evt) begin
			state_d.stack_underflow_flag = 1'b1; // see RULE1 see RULE2
		end

		// The reset request trails the flag by one cycle so the flag is
		// already visible when the rest of the device enters reset.
		state_d.fault_pend = (full_evt || unf_evt) && state_q.stack_fault_reset_enable; // see RULE1
		state_d.reset_out = state_q.fault_pend; // see RULE1 see RULE2

		// Configuration and interrupt registers.
		if (wb_wr && wb_i.adr == `RSF_OFS_CTRL) begin
			state_d.stack_fault_reset_enable = wb_i.dat[`RSF_CTRL_FRE_BIT];
		end
		if (wb_wr && wb_i.adr == `RSF_OFS_IRQ_EN) begin
			state_d.irq_en = wb_i.dat[`RSF_EVT_W-1:0];
		end
		if (wb_wr && wb_i.adr == `RSF_OFS_IRQ_CLR) begin
			state_d.irq_stat = state_q.irq_stat & ~wb_i.dat[`RSF_EVT_W-1:0];
		end
		state_d.irq_stat = state_d.irq_stat | evt;

		// Read data, captured in the same edge that raises ack.
		if (wb_i.adr == `RSF_OFS_CTRL) begin
			state_d.rdata = {31'h00000000, state_q.stack_fault_reset_enable};
		end else if (wb_i.adr == `RSF_OFS_STACK) begin
			state_d.rdata = {24'h000000, state_q.stack_full_flag,
				state_q.stack_underflow_flag, 1'b0, state_q.sp};
		end else if (wb_i.adr == `RSF_OFS_TOS) begin
			state_d.rdata = {11'h000, tos};
		end else if (wb_i.adr == `RSF_OFS_IRQ_STAT) begin
			state_d.rdata = {29'h00000000, state_q.irq_stat};
		end else if (wb_i.adr == `RSF_OFS_IRQ_EN) begin
			state_d.rdata = {29'h00000000, state_q.irq_en};
		end else begin
			state_d.rdata = `RSF_UNMAPPED_RD;
		end
		if (!wb_hit || wb_i.we) begin
			state_d.rdata = '0;
		end
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			state_q <= '0;
			state_q.stack_fault_reset_enable <= `RSF_CTRL_FRE_RST;
			state_q.irq_en <= `RSF_IRQ_EN_RST;
		end else begin
			state_q <= state_d;
		end
	end

	// Stack entries hold no reset; only entries below the pointer are read.
	always_ff @(posedge clock_i) begin
		if (mem_we) begin
			stack_mem[mem_idx] <= pc_i; // see RULE10
		end
	end

	// ------------------------------------------------------------------------
	// Shadow copy
	// ------------------------------------------------------------------------
	rsf_shadow u_shadow (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.save_i(save),
		.restore_i(restore),
		.ctx_i(ctx_i),
		.ctx_o(ctx_o),
		.restore_o(ctx_restore_o)
	);

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign wb_o.ack = state_q.ack;
	assign wb_o.dat = state_q.rdata;
	assign pc_load_o = state_q.pc_load;
	assign pc_value_o = state_q.pc_value;
	assign stack_pointer_o = state_q.sp;
	assign top_of_stack_o = tos;
	assign stack_full_flag_o = state_q.stack_full_flag;
	assign stack_underflow_flag_o = state_q.stack_underflow_flag;
	assign device_reset_o = state_q.reset_out;
	assign irq_o = |(state_q.irq_stat & state_q.irq_en);

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	logic clr_full_wr;
	assign clr_full_wr = wb_wr && wb_i.adr == `RSF_OFS_STACK && !wb_i.dat[`RSF_STACK_FULL_BIT];

	sequence s_flag_then_reset;
		##1 (stack_full_flag_o || stack_underflow_flag_o) && !device_reset_o
		##1 device_reset_o ##1 !device_reset_o;
	endsequence

	sequence s_flag_no_reset;
		##1 (stack_full_flag_o || stack_underflow_flag_o) && !device_reset_o
		##1 !device_reset_o;
	endsequence

	a_fault_then_reset: assert property (@(posedge clock_i) disable iff (!rstn_i) // see RULE1
		(full_evt || unf_evt) && state_q.stack_fault_reset_enable |-> s_flag_then_reset)
		else $error("enabled stack fault did not flag then reset");

	a_fault_no_reset: assert property (@(posedge clock_i) disable iff (!rstn_i) // see RULE2
		(full_evt || unf_evt) && !state_q.stack_fault_reset_enable && !state_q.fault_pend
		&& !state_q.reset_out |-> s_flag_no_reset)
		else $error("disabled stack fault caused a reset");

	a_full_flag_sticky: assert property (@(posedge clock_i) disable iff (!rstn_i) // see RULE3
		stack_full_flag_o && !clr_full_wr |=> stack_full_flag_o)
		else $error("full flag cleared without software write");

	a_fault_keeps_flags: assert property (@(posedge clock_i) disable iff (!rstn_i) // see RULE13
		device_reset_o && !wb_wr |=> stack_pointer_o == '0
		&& stack_full_flag_o == $past(stack_full_flag_o)
		&& stack_underflow_flag_o == $past(stack_underflow_flag_o))
		else $error("fault reset disturbed flags or pointer");

	a_vector_loads_pc: assert property (@(posedge clock_i) disable iff (!rstn_i) // see RULE9
		vec_take && !device_reset_o |=> pc_load_o
		&& pc_value_o == ($past(irq_high_i) ? `RSF_VEC_HIGH : `RSF_VEC_LOW))
		else $error("vector not loaded on interrupt");

	a_vector_pushes_pc: assert property (@(posedge clock_i) disable iff (!rstn_i) // see RULE10
		vec_take && !device_reset_o && stack_pointer_o != SP_TOP |=>
		stack_pointer_o == $past(stack_pointer_o) + `RSF_SP_W'(1)
		&& top_of_stack_o == $past(pc_i))
		else $error("program counter not pushed on interrupt");

	a_vector_saves_ctx: assert property (@(posedge clock_i) disable iff (!rstn_i) // see RULE5
		vec_take && !device_reset_o ##1 interrupt_return_op_i && fast_i && !vec_take
		&& !call_i && !device_reset_o |=> ##1 ctx_restore_o && ctx_o == $past(ctx_i, 3))
		else $error("fast return did not give the saved registers");

	a_pcl_advance: assert property (@(posedge clock_i) disable iff (!rstn_i) // see RULE12
		add_working_to_file_op_i && !vec_take && !call_i && !return_i
		&& !interrupt_return_op_i && !device_reset_o |=> pc_load_o
		&& pc_value_o == $past(pc_i) + `RSF_PC_W'($past(ctx_i.working_register)))
		else $error("computed jump did not advance by offset");

endmodule : rsf_core

/* test/rsf_seq.sv */
// Behavioural instruction sequencer and interrupt controller beside the stack block.
`timescale 1ns/100ps
`include "rsf_consts.svh"

module rsf_seq (
	input wire logic clock_i,
	input wire logic pc_load_i,
	input wire logic [`RSF_PC_W-1:0] pc_value_i,
	input wire logic ctx_restore_i,
	input wire rsf_pkg::rsf_ctx_type ctx_back_i,
	input wire logic device_reset_i,
	output logic call_o,
	output logic return_o,
	output logic iret_o,
	output logic fast_o,
	output logic vector_o,
	output logic high_o,
	output logic wake_o,
	output logic gie_low_o,
	output logic gie_high_o,
	output logic jump_o,
	output logic [`RSF_PC_W-1:0] pc_o,
	output rsf_pkg::rsf_ctx_type ctx_o
);
	initial begin
		{call_o, return_o, iret_o, fast_o, vector_o, high_o, wake_o} = '0;
		{gie_low_o, gie_high_o, jump_o} = '0;
		pc_o = '0;
		ctx_o = '0;
	end

	// ------------------------------------------------------------------------
	// Core state
	// ------------------------------------------------------------------------
	// Loads and restores land as a real core would take them, so the bench
	// judges the block by what the core ends up executing.
	always @(posedge clock_i) begin
		if (device_reset_i)
			pc_o <= '0;
		else if (pc_load_i)
			pc_o <= pc_value_i;
		if (ctx_restore_i)
			ctx_o <= ctx_back_i;
	end

	task automatic set_state(input logic [`RSF_PC_W-1:0] pc, input rsf_pkg::rsf_ctx_type ctx);
		@(posedge clock_i);
		pc_o <= pc;
		ctx_o <= ctx;
	endtask : set_state

	// ------------------------------------------------------------------------
	// One instruction or interrupt event, pulsed for one cycle
	// ------------------------------------------------------------------------
	task automatic do_op(input int code, input logic fast, input logic high, input logic gl,
		input logic gh);
		@(posedge clock_i);
		fast_o <= fast;
		high_o <= high;
		gie_low_o <= gl;
		gie_high_o <= gh;
		case (code)
			0: call_o <= 1'b1;
			1: return_o <= 1'b1;
			2: iret_o <= 1'b1;
			3: vector_o <= 1'b1;
			4: wake_o <= 1'b1;
			default: begin
				jump_o <= 1'b1;
				ctx_o.working_register[0] <= 1'b0;
			end
		endcase
		@(posedge clock_i);
		{call_o, return_o, iret_o, vector_o, wake_o, jump_o} <= '0;
		@(posedge clock_i);
		#1;
	endtask : do_op
endmodule : rsf_seq

/* test/tb_return_stack_fault_and_shadow.sv */
// Self-checking bench for the return stack fault and shadow block.
`timescale 1ns/100ps
`include "rsf_consts.svh"

module tb_return_stack_fault_and_shadow;
	localparam int CALL = 0, RET = 1, IRET = 2, VEC = 3, WAKE = 4, JMP = 5;
	logic clock_i;
	logic rstn_i;
	rsf_pkg::rsf_wb_req_type wb_req;
	rsf_pkg::rsf_wb_rsp_type wb_rsp;
	rsf_pkg::rsf_ctx_type ctx, ctx_back;
	logic call, ret, iret, fast, vec, high, wake, gie_l, gie_h, jmp;
	logic pc_load, ctx_rst, full, unf, dev_rst, irq;
	logic [`RSF_PC_W-1:0] pc, pc_val, tos;
	logic [`RSF_SP_W-1:0] sp;
	logic [31:0] rd;
	int mismatches, compares, resets_seen;

	rsf_core #(.DEPTH(31)) u_rsf_core (
		.clock_i(clock_i), .rstn_i(rstn_i), .wb_i(wb_req), .wb_o(wb_rsp),
		.call_i(call), .return_i(ret), .interrupt_return_op_i(iret), .fast_i(fast),
		.irq_vector_i(vec), .irq_high_i(high), .wake_irq_i(wake),
		.low_priority_global_enable_i(gie_l), .high_priority_global_enable_i(gie_h),
		.add_working_to_file_op_i(jmp), .pc_i(pc), .ctx_i(ctx), .pc_load_o(pc_load),
		.pc_value_o(pc_val), .ctx_restore_o(ctx_rst), .ctx_o(ctx_back),
		.stack_pointer_o(sp), .top_of_stack_o(tos), .stack_full_flag_o(full),
		.stack_underflow_flag_o(unf), .device_reset_o(dev_rst), .irq_o(irq));

	rsf_seq u_rsf_seq (
		.clock_i(clock_i), .pc_load_i(pc_load), .pc_value_i(pc_val), .ctx_restore_i(ctx_rst),
		.ctx_back_i(ctx_back), .device_reset_i(dev_rst), .call_o(call), .return_o(ret),
		.iret_o(iret), .fast_o(fast), .vector_o(vec), .high_o(high), .wake_o(wake),
		.gie_low_o(gie_l), .gie_high_o(gie_h), .jump_o(jmp), .pc_o(pc), .ctx_o(ctx));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	always @(posedge clock_i) begin
		if (dev_rst === 1'b1)
			resets_seen++;
	end

	// ------------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clock_i);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: wd};
		do begin
			@(posedge clock_i);
			n++;
		end while (wb_rsp.ack !== 1'b1 && n < 20);
		rd = wb_rsp.dat;
		if (wb_rsp.ack !== 1'b1) begin
			mismatches++;
			$display("Error at %0t: no bus answer", $time);
		end
		wb_req <= '0;
	endtask : wb

	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0);
		chk(rd, exp);
	endtask : rd_chk

	task automatic stk(input logic [31:0] p, input logic [31:0] t);
		chk(32'(sp), p);
		chk(32'(tos), t);
	endtask : stk

	task automatic end_sim;
		$display("Counts: %0d compares, %0d mismatches", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	initial begin
		#100000;
		mismatches++;
		$display("Error at %0t: watchdog expired", $time);
		end_sim();
	end

	// ------------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------------
	initial begin
		rstn_i = 1'b0;
		wb_req = '0;
		mismatches = 0;
		compares = 0;
		resets_seen = 0;
		repeat (20) @(posedge clock_i);
		rstn_i <= 1'b1;
		rd_chk(`RSF_OFS_CTRL, 32'h1);
		rd_chk(`RSF_OFS_STACK, 32'h0);
		rd_chk(`RSF_OFS_IRQ_EN, 32'h0);
		wb(1'b1, 8'h40, 32'hFFFFFFFF);
		rd_chk(8'h40, `RSF_UNMAPPED_RD);
		rd_chk(`RSF_OFS_CTRL, 32'h1);
		$display("Test reset done");
		u_rsf_seq.set_state(21'h000100, 24'h0A0B0C);
		u_rsf_seq.do_op(VEC, 1'b0, 1'b0, 1'b0, 1'b0);
		chk(32'(pc), `RSF_VEC_LOW);
		stk(1, 21'h000100);
		u_rsf_seq.set_state(`RSF_VEC_LOW, 24'h1A1B1C);
		u_rsf_seq.do_op(VEC, 1'b0, 1'b1, 1'b0, 1'b0);
		chk(32'(pc), `RSF_VEC_HIGH);
		stk(2, `RSF_VEC_LOW);
		u_rsf_seq.set_state(`RSF_VEC_HIGH, 24'h2A2B2C);
		u_rsf_seq.do_op(IRET, 1'b1, 1'b0, 1'b0, 1'b0);
		chk(32'(ctx), 24'h1A1B1C);
		chk(32'(pc), `RSF_VEC_LOW);
		u_rsf_seq.set_state(`RSF_VEC_LOW, 24'h3A3B3C);
		u_rsf_seq.do_op(IRET, 1'b0, 1'b0, 1'b0, 1'b0);
		chk(32'(ctx), 24'h3A3B3C);
		stk(0, 0);
		chk(32'(pc), 21'h000100);
		$display("Test interrupt shadow done");
		u_rsf_seq.set_state(21'h000200, 24'h4A4B4C);
		u_rsf_seq.do_op(CALL, 1'b1, 1'b0, 1'b0, 1'b0);
		stk(1, 21'h000200);
		u_rsf_seq.set_state(21'h000300, 24'h5A5B5C);
		u_rsf_seq.do_op(RET, 1'b1, 1'b0, 1'b0, 1'b0);
		chk(32'(ctx), 24'h4A4B4C);
		chk(32'(pc), 21'h000200);
		$display("Test fast call done");
		u_rsf_seq.set_state(21'h000300, 24'h000000);
		u_rsf_seq.do_op(WAKE, 1'b0, 1'b1, 1'b0, 1'b0);
		chk(32'(pc), 21'h000300);
		u_rsf_seq.do_op(WAKE, 1'b0, 1'b0, 1'b1, 1'b0);
		chk(32'(pc), `RSF_VEC_LOW);
		stk(1, 21'h000300);
		u_rsf_seq.do_op(WAKE, 1'b0, 1'b1, 1'b0, 1'b1);
		chk(32'(pc), `RSF_VEC_HIGH);
		stk(2, `RSF_VEC_LOW);
		u_rsf_seq.do_op(RET, 1'b0, 1'b0, 1'b0, 1'b0);
		u_rsf_seq.do_op(RET, 1'b0, 1'b0, 1'b0, 1'b0);
		chk(32'(pc), 21'h000300);
		$display("Test wake done");
		u_rsf_seq.set_state(21'h0001F0, 24'h001600);
		u_rsf_seq.do_op(JMP, 1'b0, 1'b0, 1'b0, 1'b0);
		chk(32'(pc), 21'h000206);
		$display("Test computed jump done");
		wb(1'b1, `RSF_OFS_CTRL, 32'h0);
		wb(1'b1, `RSF_OFS_IRQ_EN, 32'h2);
		u_rsf_seq.do_op(RET, 1'b0, 1'b0, 1'b0, 1'b0);
		repeat (3) @(posedge clock_i);
		rd_chk(`RSF_OFS_STACK, 32'h40);
		chk(32'(resets_seen), 0);
		chk(32'(irq), 1);
		u_rsf_seq.do_op(CALL, 1'b0, 1'b0, 1'b0, 1'b0);
		u_rsf_seq.do_op(RET, 1'b0, 1'b0, 1'b0, 1'b0);
		wb(1'b1, `RSF_OFS_IRQ_CLR, 32'h2);
		rd_chk(`RSF_OFS_STACK, 32'h40);
		chk(32'(irq), 0);
		wb(1'b1, `RSF_OFS_STACK, 32'hC0);
		rd_chk(`RSF_OFS_STACK, 32'h40);
		wb(1'b1, `RSF_OFS_STACK, 32'h0);
		rd_chk(`RSF_OFS_STACK, 32'h0);
		$display("Test underflow done");
		wb(1'b1, `RSF_OFS_CTRL, 32'h1);
		for (int i = 0; i < 31; i++) begin
			u_rsf_seq.do_op(CALL, 1'b0, 1'b0, 1'b0, 1'b0);
		end
		chk(32'(sp), 31);
		u_rsf_seq.do_op(CALL, 1'b0, 1'b0, 1'b0, 1'b0);
		chk(32'(full), 1);
		chk(32'(resets_seen), 0);
		repeat (3) @(posedge clock_i);
		#1;
		chk(32'(resets_seen), 1);
		rd_chk(`RSF_OFS_STACK, 32'h80);
		rd_chk(`RSF_OFS_IRQ_STAT, 32'h5);
		$display("Test overflow done");
		end_sim();
	end
endmodule : tb_return_stack_fault_and_shadow
